// [verilog/micro_ram_pkg.sv]
/*
 Constants, field layouts and carrier types shared by the three-port micro RAM and
 its read-port slice. Assumes a single 125 MHz core clock; every port clock pin
 arrives as a plain input that is synchronous to that clock.
*/

`default_nettype none

package micro_ram_pkg;

   //------------------------------------------------------------
   // Array geometry
   //------------------------------------------------------------
   localparam int ADDR_W = 10;
   localparam int DATA_W = 18;
   localparam int WORDS = 64;
   localparam int TOTAL_BITS = 1152;
   localparam int WORD_LSB = 4;
   localparam logic [1:0] SEL_ON = 2'h3;
   localparam logic [2:0] WIDTH_X1 = 3'h0;
   localparam logic [2:0] WIDTH_X2 = 3'h1;
   localparam logic [2:0] WIDTH_X4 = 3'h2;
   localparam logic [2:0] WIDTH_X9 = 3'h3;
   localparam logic [2:0] WIDTH_X18 = 3'h4;

   //------------------------------------------------------------
   // Register map (byte addresses) and field positions
   //------------------------------------------------------------
   localparam int AVS_ADDR_W = 4;
   localparam logic [3:0] CFG_OFFSET = 4'h0;
   localparam logic [3:0] STATUS_OFFSET = 4'h4;
   localparam int CFG_W = 15;
   localparam int CFG_RD1_WIDTH_POS = 0;
   localparam int CFG_RD2_WIDTH_POS = 3;
   localparam int CFG_WR_WIDTH_POS = 6;
   localparam int CFG_RD1_ADDR_LAT_POS = 9;
   localparam int CFG_RD1_PIPE_LAT_POS = 10;
   localparam int CFG_RD1_BYPASS_POS = 11;
   localparam int CFG_RD2_ADDR_LAT_POS = 12;
   localparam int CFG_RD2_PIPE_LAT_POS = 13;
   localparam int CFG_RD2_BYPASS_POS = 14;
   localparam logic [14:0] CFG_RESET = 15'h0124;
   localparam int ST_RD1_ADDR_POS = 0;
   localparam int ST_RD1_SEL_POS = 10;
   localparam int ST_RD2_ADDR_POS = 16;
   localparam int ST_RD2_SEL_POS = 26;

   //------------------------------------------------------------
   // Carrier types
   //------------------------------------------------------------
   typedef struct packed {
      logic [9:0] addr;
      logic [1:0] blockSelect;
      logic addrClk;
      logic addrEn;
      logic addrSyncClearN;
      logic addrAsyncClearN;
      logic pipeClk;
      logic pipeEn;
      logic pipeSyncClearN;
      logic pipeAsyncClearN;
   } rd_pins_s;

   typedef struct packed {
      logic [2:0] width;
      logic addrLatchMode;
      logic pipeLatchMode;
      logic pipeBypass;
   } rd_cfg_s;

   typedef struct packed {
      logic [9:0] addr;
      logic [1:0] blockSelect;
      logic clk;
      logic enable;
      logic [17:0] data;
   } wr_pins_s;

endpackage

`default_nettype wire

// [verilog/read_port.sv]
/*
 One read port: address/select register (clocked or latch), lane extraction and
 output register (clocked, latch or bypass). Assumes the caller hands back the
 array word addressed by capAddr in the same cycle.
*/
`timescale 1ns/10ps
`default_nettype none

module read_port #(
   parameter int ADDR_W = 10,
   parameter int DATA_W = 18
)(
   input wire logic core_clk,
   input wire logic rst,
   input wire micro_ram_pkg::rd_pins_s pins,
   input wire micro_ram_pkg::rd_cfg_s cfg,
   input wire logic [DATA_W-1:0] memWord,
   output logic [ADDR_W-1:0] capAddr,
   output logic [1:0] capSel,
   output logic [DATA_W-1:0] rdData
);

   if (ADDR_W != micro_ram_pkg::ADDR_W || DATA_W != micro_ram_pkg::DATA_W)
   begin : g_bad_geometry
      $error("read_port supports only a 10-bit address and 18-bit data");
   end

   logic addrArstN;
   logic pipeArstN;
   logic addrClkPrev;
   logic pipeClkPrev;
   logic addrEdge;
   logic pipeEdge;
   logic [11:0] addrHeld;
   logic [11:0] next_addrHeld;
   logic [17:0] pipeHeld;
   logic [17:0] next_pipeHeld;
   logic [17:0] liveData;

   assign addrArstN = pins.addrAsyncClearN;
   assign pipeArstN = pins.pipeAsyncClearN;

   //------------------------------------------------------------
   // Lane extraction
   //------------------------------------------------------------
   function automatic logic [17:0] lane_read(input logic [17:0] word, input logic [9:0] addr,
                                             input logic [2:0] width);
      logic [15:0] p16;
      logic [17:0] res;
      p16 = {word[16:9], word[7:0]};
      case (width)
         micro_ram_pkg::WIDTH_X1: res = {17'h00000, p16[addr[3:0]]};
         micro_ram_pkg::WIDTH_X2: res = {16'h0000, p16[{addr[3:1], 1'b0} +: 2]};
         micro_ram_pkg::WIDTH_X4: res = {14'h0000, p16[{addr[3:2], 2'b00} +: 4]};
         micro_ram_pkg::WIDTH_X9: res = {9'h000, (addr[3] ? word[17:9] : word[8:0])};
         default: res = word;
      endcase
      return res;
   endfunction

   //------------------------------------------------------------
   // Address/select register
   //------------------------------------------------------------
   // Next held value: edge in clocked mode, clock-high window in latch mode
   always_comb
   begin
      addrEdge = pins.addrClk & ~addrClkPrev;
      next_addrHeld = addrHeld;
      if (cfg.addrLatchMode ? pins.addrClk : addrEdge)
      begin
         if (!pins.addrSyncClearN)
            next_addrHeld = 12'h000;
         else if (pins.addrEn)
            next_addrHeld = {pins.addr, pins.blockSelect};
      end
   end

   // Register stage, cleared at once by the async clear
   always_ff @(posedge core_clk or posedge rst or negedge addrArstN)
   begin
      if (rst)
         addrHeld <= 12'h000;
      else if (!addrArstN)
         addrHeld <= 12'h000;
      else
         addrHeld <= next_addrHeld;
   end

   // Output of the address stage, transparent while a latch is open
   always_comb
   begin
      if (!addrArstN)
         {capAddr, capSel} = 12'h000;
      else if (cfg.addrLatchMode && pins.addrClk)
         {capAddr, capSel} = next_addrHeld;
      else
         {capAddr, capSel} = addrHeld;
   end

   // Deselected port reads zero
   assign liveData = (capSel == micro_ram_pkg::SEL_ON) ?
                     lane_read(memWord, capAddr, cfg.width) : 18'h00000;

   //------------------------------------------------------------
   // Output pipeline register
   //------------------------------------------------------------
   always_comb
   begin
      pipeEdge = pins.pipeClk & ~pipeClkPrev;
      next_pipeHeld = pipeHeld;
      if (cfg.pipeLatchMode ? pins.pipeClk : pipeEdge)
      begin
         if (!pins.pipeSyncClearN)
            next_pipeHeld = 18'h00000;
         else if (pins.pipeEn)
            next_pipeHeld = liveData;
      end
   end

   always_ff @(posedge core_clk or posedge rst or negedge pipeArstN)
   begin
      if (rst)
         pipeHeld <= 18'h00000;
      else if (!pipeArstN)
         pipeHeld <= 18'h00000;
      else
         pipeHeld <= next_pipeHeld;
   end

   // Clock pin history; reset high so an idle-high pin gives no false edge
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         addrClkPrev <= 1'b1;
         pipeClkPrev <= 1'b1;
      end
      else
      begin
         addrClkPrev <= pins.addrClk;
         pipeClkPrev <= pins.pipeClk;
      end
   end

   // Read mode select: bypass, open latch or held register
   always_comb
   begin
      if (!pipeArstN)
         rdData = 18'h00000;
      else if (cfg.pipeBypass)
         rdData = liveData;
      else if (cfg.pipeLatchMode && pins.pipeClk)
         rdData = next_pipeHeld;
      else
         rdData = pipeHeld;
   end

   //------------------------------------------------------------
   // Checks
   //------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   sequence s_addr_capture;
      !cfg.addrLatchMode && addrEdge && pins.addrEn && pins.addrSyncClearN && addrArstN;
   endsequence

   sequence s_pipe_load;
      !cfg.pipeBypass && !cfg.pipeLatchMode && pipeEdge && pins.pipeEn &&
      pins.pipeSyncClearN && pipeArstN;
   endsequence

   chk_addr_async_clear: assert property (!addrArstN |-> capAddr == 10'h000 && capSel == 2'h0)
      else $error("address stage not cleared by async clear");
   chk_addr_capture: assert property (s_addr_capture |=> !addrArstN || cfg.addrLatchMode ||
      (capAddr == $past(pins.addr) && capSel == $past(pins.blockSelect)))
      else $error("address not captured on clock edge");
   chk_addr_sync_clear: assert property (!cfg.addrLatchMode && addrEdge && !pins.addrSyncClearN
      |=> cfg.addrLatchMode || capSel == 2'h0)
      else $error("address stage not cleared synchronously");
   chk_addr_latch_open: assert property (cfg.addrLatchMode && pins.addrClk && pins.addrEn &&
      pins.addrSyncClearN && addrArstN |-> capAddr == pins.addr)
      else $error("open address latch not transparent");
   chk_deselect_zero: assert property (capSel != micro_ram_pkg::SEL_ON |-> liveData == 18'h00000)
      else $error("deselected port returned data");
   chk_pipe_load: assert property (s_pipe_load |=> !pipeArstN || cfg.pipeBypass ||
      cfg.pipeLatchMode || rdData == $past(liveData))
      else $error("output register did not load");
   chk_pipe_hold: assert property (!cfg.pipeBypass && !cfg.pipeLatchMode && !pipeEdge &&
      pipeArstN |=> !pipeArstN || cfg.pipeBypass || cfg.pipeLatchMode || $stable(rdData))
      else $error("output register changed without clock edge");
   chk_pipe_async_clear: assert property (!pipeArstN |-> rdData == 18'h00000)
      else $error("read data not cleared by async clear");

endmodule

`default_nettype wire

// [verilog/three_port_micro_ram.sv]
/*
 Three-port micro RAM: 1,152-bit array, two read ports, one write port, and an
 Avalon-MM slave for width and read-mode configuration plus captured state.
 Assumes every port pin is synchronous to core_clk; port clock pins are sampled.
*/
// Implementation choices: the address map and register access over Avalon-MM.
`timescale 1ns/10ps
`default_nettype none

module three_port_micro_ram #(
   parameter int WORDS = 64,
   parameter int DATA_W = 18
)(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire micro_ram_pkg::rd_pins_s rd1Pins,
   input wire micro_ram_pkg::rd_pins_s rd2Pins,
   input wire micro_ram_pkg::wr_pins_s wrPins,
   output logic [17:0] rd1Data,
   output logic [17:0] rd2Data
);

   if (WORDS * DATA_W != micro_ram_pkg::TOTAL_BITS || DATA_W != micro_ram_pkg::DATA_W)
   begin : g_bad_size
      $error("array must be 64 words of 18 bits");
   end

   //------------------------------------------------------------
   // Declarations
   //------------------------------------------------------------
   logic [17:0] mem [WORDS];
   logic [14:0] cfg;
   logic [14:0] next_cfg;
   logic ack;
   logic next_ack;
   logic [31:0] readData;
   logic [31:0] next_readData;
   logic [31:0] statusWord;
   logic [31:0] cfgWord;
   micro_ram_pkg::rd_cfg_s rd1Cfg;
   micro_ram_pkg::rd_cfg_s rd2Cfg;
   logic [2:0] wrWidth;
   logic wrClkPrev;
   logic wrEdge;
   logic writeHit;
   logic [5:0] wrIdx;
   logic [17:0] nextWord;
   logic [9:0] rd1CapAddr;
   logic [9:0] rd2CapAddr;
   logic [1:0] rd1CapSel;
   logic [1:0] rd2CapSel;
   logic [17:0] rd1Word;
   logic [17:0] rd2Word;

   //------------------------------------------------------------
   // Write-lane merge
   //------------------------------------------------------------
   function automatic logic [17:0] lane_write(input logic [17:0] word, input logic [9:0] addr,
                                              input logic [2:0] width, input logic [17:0] din);
      logic [15:0] p16;
      logic [17:0] res;
      p16 = {word[16:9], word[7:0]};
      case (width)
         micro_ram_pkg::WIDTH_X1: p16[addr[3:0]] = din[0];
         micro_ram_pkg::WIDTH_X2: p16[{addr[3:1], 1'b0} +: 2] = din[1:0];
         micro_ram_pkg::WIDTH_X4: p16[{addr[3:2], 2'b00} +: 4] = din[3:0];
         default: p16 = p16;
      endcase
      res = {word[17], p16[15:8], word[8], p16[7:0]};
      if (width == micro_ram_pkg::WIDTH_X9)
         res = addr[3] ? {din[8:0], word[8:0]} : {word[17:9], din[8:0]};
      else if (width > micro_ram_pkg::WIDTH_X9)
         res = din;
      return res;
   endfunction

   //------------------------------------------------------------
   // Configuration fields
   //------------------------------------------------------------
   // Unpack the config register into per-port settings
   always_comb
   begin
      rd1Cfg.width = cfg[micro_ram_pkg::CFG_RD1_WIDTH_POS +: 3];
      rd1Cfg.addrLatchMode = cfg[micro_ram_pkg::CFG_RD1_ADDR_LAT_POS];
      rd1Cfg.pipeLatchMode = cfg[micro_ram_pkg::CFG_RD1_PIPE_LAT_POS];
      rd1Cfg.pipeBypass = cfg[micro_ram_pkg::CFG_RD1_BYPASS_POS];
      rd2Cfg.width = cfg[micro_ram_pkg::CFG_RD2_WIDTH_POS +: 3];
      rd2Cfg.addrLatchMode = cfg[micro_ram_pkg::CFG_RD2_ADDR_LAT_POS];
      rd2Cfg.pipeLatchMode = cfg[micro_ram_pkg::CFG_RD2_PIPE_LAT_POS];
      rd2Cfg.pipeBypass = cfg[micro_ram_pkg::CFG_RD2_BYPASS_POS];
      wrWidth = cfg[micro_ram_pkg::CFG_WR_WIDTH_POS +: 3];
   end

   // Captured read-port state for software
   always_comb
   begin
      statusWord = 32'h00000000;
      statusWord[micro_ram_pkg::ST_RD1_ADDR_POS +: 10] = rd1CapAddr;
      statusWord[micro_ram_pkg::ST_RD1_SEL_POS +: 2] = rd1CapSel;
      statusWord[micro_ram_pkg::ST_RD2_ADDR_POS +: 10] = rd2CapAddr;
      statusWord[micro_ram_pkg::ST_RD2_SEL_POS +: 2] = rd2CapSel;
   end

   //------------------------------------------------------------
   // Avalon-MM slave: one wait state on every access
   //------------------------------------------------------------
   assign avs_waitrequest = (avs_read | avs_write) & ~ack;
   assign avs_readdata = readData;

   // Next ack, read data and config
   always_comb
   begin
      next_ack = (avs_read | avs_write) & ~ack;
      next_readData = readData;
      cfgWord = {17'h00000, cfg};
      if (avs_read && !ack)
      begin
         if (avs_address == micro_ram_pkg::CFG_OFFSET)
            next_readData = cfgWord;
         else if (avs_address == micro_ram_pkg::STATUS_OFFSET)
            next_readData = statusWord;
         else
            next_readData = 32'h00000000;
      end
      if (avs_write && ack && avs_address == micro_ram_pkg::CFG_OFFSET)
      begin
         for (int b = 0; b < 4; b++)
         begin
            if (avs_byteenable[b])
               cfgWord[8*b +: 8] = avs_writedata[8*b +: 8];
         end
      end
      next_cfg = cfgWord[14:0];
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         ack <= 1'b0;
         readData <= 32'h00000000;
         cfg <= micro_ram_pkg::CFG_RESET;
      end
      else
      begin
         ack <= next_ack;
         readData <= next_readData;
         cfg <= next_cfg;
      end
   end

   //------------------------------------------------------------
   // Write port
   //------------------------------------------------------------
   // Write on the sampled write clock's rising edge only
   always_comb
   begin
      wrEdge = wrPins.clk & ~wrClkPrev;
      writeHit = wrEdge && wrPins.enable &&
                 wrPins.blockSelect == micro_ram_pkg::SEL_ON;
      wrIdx = wrPins.addr[9:micro_ram_pkg::WORD_LSB];
      nextWord = lane_write(mem[wrIdx], wrPins.addr, wrWidth, wrPins.data);
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         wrClkPrev <= 1'b1;
      else
         wrClkPrev <= wrPins.clk;
   end

   // Array update; both reads see the new word from the next cycle
   always_ff @(posedge core_clk)
   begin
      if (writeHit)
         mem[wrIdx] <= nextWord;
   end

   //------------------------------------------------------------
   // Read ports
   //------------------------------------------------------------
   // Each port addresses the array independently
   assign rd1Word = mem[rd1CapAddr[9:micro_ram_pkg::WORD_LSB]];
   assign rd2Word = mem[rd2CapAddr[9:micro_ram_pkg::WORD_LSB]];

   read_port #(
      .ADDR_W(micro_ram_pkg::ADDR_W),
      .DATA_W(micro_ram_pkg::DATA_W)
   ) u_rd1 (
      .core_clk(core_clk),
      .rst(rst),
      .pins(rd1Pins),
      .cfg(rd1Cfg),
      .memWord(rd1Word),
      .capAddr(rd1CapAddr),
      .capSel(rd1CapSel),
      .rdData(rd1Data)
   );

   read_port #(
      .ADDR_W(micro_ram_pkg::ADDR_W),
      .DATA_W(micro_ram_pkg::DATA_W)
   ) u_rd2 (
      .core_clk(core_clk),
      .rst(rst),
      .pins(rd2Pins),
      .cfg(rd2Cfg),
      .memWord(rd2Word),
      .capAddr(rd2CapAddr),
      .capSel(rd2CapSel),
      .rdData(rd2Data)
   );

   //------------------------------------------------------------
   // Checks
   //------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   sequence s_cfg_write;
      avs_write && ack && avs_address == micro_ram_pkg::CFG_OFFSET && avs_byteenable == 4'hf;
   endsequence

   sequence s_same_read;
      rd1CapAddr == rd2CapAddr && rd1CapSel == micro_ram_pkg::SEL_ON &&
      rd2CapSel == micro_ram_pkg::SEL_ON && rd1Cfg.width == rd2Cfg.width &&
      rd1Cfg.pipeBypass && rd2Cfg.pipeBypass && rd1Pins.pipeAsyncClearN &&
      rd2Pins.pipeAsyncClearN;
   endsequence

   chk_write_store: assert property (writeHit |=> mem[$past(wrIdx)] == $past(nextWord))
      else $error("write data not stored");
   chk_write_needs_edge: assert property (!writeHit |=> mem[$past(wrIdx)] === $past(mem[wrIdx]))
      else $error("array changed without a write clock edge");
   chk_same_address: assert property (s_same_read |-> rd1Data == rd2Data)
      else $error("ports disagree on the same address");
   chk_upper_zero_x4: assert property (rd1Cfg.width == micro_ram_pkg::WIDTH_X4 &&
      rd1Cfg.pipeBypass |-> rd1Data[17:4] == 14'h0000)
      else $error("bits above x4 width not zero");
   chk_upper_zero_x1: assert property (rd2Cfg.width == micro_ram_pkg::WIDTH_X1 &&
      rd2Cfg.pipeBypass |-> rd2Data[17:1] == 17'h00000)
      else $error("bits above x1 width not zero");
   chk_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=>
      !avs_waitrequest)
      else $error("bus request not answered in one wait state");
   chk_cfg_write: assert property (s_cfg_write |=> cfg == $past(avs_writedata[14:0]))
      else $error("config write not applied");

endmodule

`default_nettype wire

// [tb/fabric_model.sv]
/*
 Fabric-side model driving the read and write pin bundles of the micro RAM.
 Assumes its tasks are called from one bench process, one at a time.
*/
`timescale 1ns/10ps
`default_nettype none

module fabric_model (
   input wire logic core_clk,
   output var micro_ram_pkg::rd_pins_s rd1Pins,
   output var micro_ram_pkg::rd_pins_s rd2Pins,
   output var micro_ram_pkg::wr_pins_s wrPins
);
   // Second port mirrors the first: same address at once
   assign rd2Pins = rd1Pins;

   // Idle levels: clears released, read enables high, write enable and clocks low
   initial
   begin
      rd1Pins = '0;
      rd1Pins.addrEn = 1'b1;
      rd1Pins.addrSyncClearN = 1'b1;
      rd1Pins.addrAsyncClearN = 1'b1;
      rd1Pins.pipeEn = 1'b1;
      rd1Pins.pipeSyncClearN = 1'b1;
      rd1Pins.pipeAsyncClearN = 1'b1;
      wrPins = '0;
   end

   //------------------------------------------------------------
   // Port tasks
   //------------------------------------------------------------
   // One write-clock rise; lines inverted and deselected after it
   task automatic wr(input logic [9:0] a, input logic [17:0] d, input logic en);
      @(posedge core_clk);
      wrPins <= {a, micro_ram_pkg::SEL_ON, 1'b1, en, d};
      @(posedge core_clk);
      wrPins <= {~a, 2'h0, 1'b0, 1'b0, ~d};
   endtask

   // Address edge, then output edge; never overlaps a write
   task automatic rd(input logic [9:0] a, input logic [1:0] s);
      @(posedge core_clk);
      rd1Pins.addrClk <= 1'b1;
      rd1Pins.addr <= a;
      rd1Pins.blockSelect <= s;
      @(posedge core_clk);
      rd1Pins.addrClk <= 1'b0;
      rd1Pins.addr <= ~a;
      rd1Pins.pipeClk <= 1'b1;
      @(posedge core_clk);
      rd1Pins.pipeClk <= 1'b0;
   endtask

   // Clear pins: address sync clear, both async clears
   task automatic clr(input logic syncN, input logic asyncN);
      @(posedge core_clk);
      rd1Pins.addrSyncClearN <= syncN;
      rd1Pins.addrAsyncClearN <= asyncN;
      rd1Pins.pipeAsyncClearN <= asyncN;
   endtask
endmodule

`default_nettype wire

// [tb/testbench.sv]
/*
 Self-checking bench for the three-port micro RAM: Avalon access to the
 settings and status words, fabric traffic through the pin model.
 Assumes one bus wait state and clocked-clocked reads after reset.
*/
`timescale 1ns/10ps
`default_nettype none

module testbench;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'hf;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [17:0] rd1Data;
   logic [17:0] rd2Data;
   logic [31:0] q;
   int errTotal = 0;
   int nChecks = 0;
   int cycles = 0;
   micro_ram_pkg::rd_pins_s rd1Pins;
   micro_ram_pkg::rd_pins_s rd2Pins;
   micro_ram_pkg::wr_pins_s wrPins;

   three_port_micro_ram three_port_micro_ram_i (
      .core_clk(core_clk), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .rd1Pins(rd1Pins), .rd2Pins(rd2Pins),
      .wrPins(wrPins), .rd1Data(rd1Data), .rd2Data(rd2Data));

   fabric_model fabric_model_i (
      .core_clk(core_clk), .rd1Pins(rd1Pins), .rd2Pins(rd2Pins), .wrPins(wrPins));

   // Clock and hang ceiling
   always #4 core_clk = ~core_clk;
   always @(posedge core_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 2000)
      begin
         errTotal++;
         tally_and_finish();
      end
   end

   //------------------------------------------------------------
   // Tasks
   //------------------------------------------------------------
   // Avalon access, held until waitrequest is seen low
   task automatic bus(input logic w, input logic [3:0] a, input logic [3:0] be,
      input logic [31:0] d);
      @(posedge core_clk);
      avs_address <= a;
      avs_write <= w;
      avs_read <= ~w;
      avs_byteenable <= be;
      avs_writedata <= d;
      do
         @(posedge core_clk);
      while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask

   // Compare seen against expected
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      nChecks++;
      if (got !== exp)
      begin
         errTotal++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // Counts and verdict
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", nChecks, errTotal);
      if (errTotal == 0 && nChecks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Main sequence
   initial
   begin
      repeat (10) @(posedge core_clk);
      rst <= 1'b0;
      bus(1'b0, micro_ram_pkg::CFG_OFFSET, 4'hf, 32'h0);
      chk("config", q, 32'h00000124);
      bus(1'b0, 4'h8, 4'hf, 32'h0);
      chk("unmapped", q, 32'h0);
      $display("test bus done");
      fabric_model_i.wr(10'h010, 18'h2a5c3, 1'b1);
      fabric_model_i.wr(10'h3f0, 18'h15a3c, 1'b1);
      fabric_model_i.wr(10'h010, 18'h00001, 1'b0);
      fabric_model_i.rd(10'h3f0, 2'h3);
      @(posedge core_clk);
      chk("rd1 top", rd1Data, 18'h15a3c);
      chk("rd2 top", rd2Data, 18'h15a3c);
      bus(1'b0, micro_ram_pkg::STATUS_OFFSET, 4'hf, 32'h0);
      chk("status", q, 32'h0ff00ff0);
      fabric_model_i.clr(1'b0, 1'b1);
      fabric_model_i.rd(10'h3f0, 2'h3);
      @(posedge core_clk);
      chk("sync clear", rd1Data, 18'h0);
      fabric_model_i.clr(1'b1, 1'b1);
      fabric_model_i.rd(10'h010, 2'h3);
      @(posedge core_clk);
      chk("rd1 word", rd1Data, 18'h2a5c3);
      chk("rd2 word", rd2Data, 18'h2a5c3);
      fabric_model_i.rd(10'h010, 2'h1);
      @(posedge core_clk);
      chk("deselect", rd1Data, 18'h0);
      $display("test array done");
      bus(1'b1, micro_ram_pkg::CFG_OFFSET, 4'hf, 32'h00000122);
      fabric_model_i.rd(10'h014, 2'h3);
      @(posedge core_clk);
      chk("rd1 x4 lane", rd1Data, 18'h0000c);
      chk("rd2 x18", rd2Data, 18'h2a5c3);
      fabric_model_i.clr(1'b1, 1'b0);
      @(posedge core_clk);
      chk("async clear", rd1Data, 18'h0);
      bus(1'b0, micro_ram_pkg::STATUS_OFFSET, 4'hf, 32'h0);
      chk("status clear", q, 32'h0);
      fabric_model_i.clr(1'b1, 1'b1);
      bus(1'b1, micro_ram_pkg::CFG_OFFSET, 4'h2, 32'h0);
      bus(1'b0, micro_ram_pkg::CFG_OFFSET, 4'hf, 32'h0);
      chk("byte lanes", q, 32'h00000022);
      $display("test width done");
      bus(1'b1, micro_ram_pkg::CFG_OFFSET, 4'hf, 32'h00004902);
      fabric_model_i.rd(10'h01c, 2'h3);
      @(posedge core_clk);
      chk("rd1 x4 bypass", rd1Data, 18'h00005);
      chk("rd2 x1 bypass", rd2Data, 18'h00001);
      bus(1'b1, micro_ram_pkg::CFG_OFFSET, 4'hf, 32'h00004924);
      fabric_model_i.rd(10'h010, 2'h3);
      @(posedge core_clk);
      chk("rd1 bypass", rd1Data, 18'h2a5c3);
      chk("rd2 bypass", rd2Data, 18'h2a5c3);
      bus(1'b1, micro_ram_pkg::CFG_OFFSET, 4'hf, 32'h00003b24);
      fabric_model_i.rd(10'h3f0, 2'h3);
      @(posedge core_clk);
      chk("rd1 latch", rd1Data, 18'h15a3c);
      chk("rd2 latch", rd2Data, 18'h15a3c);
      $display("test modes done");
      tally_and_finish();
   end
endmodule

`default_nettype wire
